// *** common/branch_unit_cfg.svh ***
// Constants for the conditional branch unit: offsets, fields, resets, timing
//
// Behaviour
// - Opcode 0x38 branches only while signed_wrap_flag is clear.
// - Opcode 0x3A branches only while equal_result_flag is clear.
// - Opcode 0x0C branches only while acc_a_overflow_flag is set.
// - Opcode 0x0D branches only while acc_b_overflow_flag is set.
// - Opcode 0x30 branches only while signed_wrap_flag is set.
// - Taken target is current counter plus 2 plus twice the offset.
// - The 16 offset bits are two's complement, -32768 to +32767.
// - Offset counts instructions from the next address, not bytes.
// - A taken branch loads a NOP to squash the fetched follower.
// - Base core: 1 cycle not taken, 2 cycles taken.
// - Enhanced core: 1 cycle not taken, 4 cycles taken.
// - No branch of this group alters any status_word flag.
`ifndef BRANCH_UNIT_CFG_SVH
`define BRANCH_UNIT_CFG_SVH

// Widths
`define PC_W 24
`define INSTR_W 24
`define OPC_W 8
`define OFS_W 16

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS_WORD 8'h04
`define REG_PC 8'h08
`define REG_INSTR 8'h0C
`define REG_RESULT 8'h10
`define REG_TARGET 8'h14

// Control fields
`define CTRL_ENHANCED_BIT 0
`define CTRL_DSP_BIT 1
`define CTRL_RESET 2'h0

// Status word fields
`define SW_WRAP_BIT 0
`define SW_EQUAL_BIT 1
`define SW_ACC_A_BIT 2
`define SW_ACC_B_BIT 3
`define SW_RESET 4'h0

// Result fields, then the counter reset value
`define RES_BUSY_BIT 0
`define RES_TAKEN_BIT 1
`define RES_UNIMPL_BIT 2
`define RES_CYC_LSB 4
`define PC_RESET 24'h000000

// Opcode prefixes
`define OPC_UNLESS_WRAP 8'h38
`define OPC_UNLESS_EQUAL 8'h3A
`define OPC_ACC_A_OVF 8'h0C
`define OPC_ACC_B_OVF 8'h0D
`define OPC_WRAP 8'h30

// Instruction size in bytes, timing in core cycles
`define INSTR_BYTES 24'h000002
`define CYC_NOT_TAKEN 3'h1
`define CYC_TAKEN_BASE 3'h2
`define CYC_TAKEN_ENH 3'h4

`endif

// *** common/branch_unit_pkg.sv ***
// Types shared by the conditional branch unit files
`include "branch_unit_cfg.svh"

package branch_unit_pkg;

  // One-hot execution states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_FLUSH = 3'b100
  } unit_fsm_t;

  // Latched condition flags
  typedef struct packed {
    logic acc_b_overflow_flag;
    logic acc_a_overflow_flag;
    logic equal_result_flag;
    logic signed_wrap_flag;
  } flag_set_t;

  // Decoder verdict
  typedef struct packed {
    logic known;
    logic taken;
  } branch_verdict_t;

  // Whole state of the top module
  typedef struct packed {
    unit_fsm_t state;
    logic enhanced;
    logic dsp_present;
    flag_set_t status_word;
    logic [`PC_W-1:0] pc;
    logic [`INSTR_W-1:0] instr;
    logic [`PC_W-1:0] target;
    logic [1:0] wait_cnt;
    logic last_taken;
    logic unimpl;
    logic [2:0] cycles;
    logic pc_load;
    logic nop_load;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic busy;
  } unit_state_t;

endpackage : branch_unit_pkg

// *** rtl/branch_decode.sv ***
// Opcode decoder and condition test for the conditional branch group
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module branch_decode (
  input wire logic [`OPC_W-1:0] opcode, // Instruction prefix byte
  input wire branch_unit_pkg::flag_set_t flags, // Flags latched at start
  input wire logic dsp_present, // Core has DSP accumulators
  output branch_unit_pkg::branch_verdict_t verdict // Known and taken
);
  import branch_unit_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // True when the opcode names an accumulator branch
  function automatic logic is_acc_branch(input logic [`OPC_W-1:0] opc);
    is_acc_branch = (opc == `OPC_ACC_A_OVF) || (opc == `OPC_ACC_B_OVF);
  endfunction : is_acc_branch

  ////////////////////////////////////////////////////////////////////////
  // Condition test per prefix
  always_comb
  begin
    verdict.known = 1'b1;
    verdict.taken = 1'b0;
    unique case (opcode)
      `OPC_UNLESS_WRAP: verdict.taken = !flags.signed_wrap_flag;
      `OPC_UNLESS_EQUAL: verdict.taken = !flags.equal_result_flag;
      `OPC_ACC_A_OVF: verdict.taken = flags.acc_a_overflow_flag;
      `OPC_ACC_B_OVF: verdict.taken = flags.acc_b_overflow_flag;
      `OPC_WRAP: verdict.taken = flags.signed_wrap_flag;
      default: verdict.known = 1'b0;
    endcase
    if (is_acc_branch(opcode) && !dsp_present)
    begin
      verdict.known = 1'b0;
      verdict.taken = 1'b0;
    end
  end

endmodule : branch_decode

// *** rtl/conditional_branch_unit.sv ***
// Conditional relative branch unit with an AHB-Lite register slave
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module conditional_branch_unit (
  input wire logic sys_clk, // Core clock, 40 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB byte address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write when high
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic hready, // AHB bus ready
  input wire logic [31:0] hwdata, // AHB write data
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [`PC_W-1:0] pc_value, // Program counter to fetch
  output logic pc_load, // Pulse: pc_value was updated
  output logic nop_load, // Pulse: squash follower with NOP
  output logic busy // Branch in progress
);
  import branch_unit_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State and decoder hookup

  unit_state_t st;
  unit_state_t next_st;
  branch_verdict_t verdict;
  logic addr_phase;
  logic [`OFS_W-1:0] offset;
  logic [`PC_W-1:0] seq_pc;
  logic [`PC_W-1:0] jump_pc;
  logic [2:0] taken_cycles;

  // Flags come from the latched status word, so decode sees the start value
  branch_decode u_decode (
    .opcode (st.instr[`INSTR_W-1 -: `OPC_W]),
    .flags (st.status_word),
    .dsp_present (st.dsp_present),
    .verdict (verdict)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer for the register map
  function automatic logic [31:0] read_word(
    input logic [7:0] addr,
    input unit_state_t s
  );
    logic [31:0] w;
    w = 32'h00000000;
    unique case (addr)
      `REG_CTRL:
      begin
        w[`CTRL_ENHANCED_BIT] = s.enhanced;
        w[`CTRL_DSP_BIT] = s.dsp_present;
      end
      `REG_STATUS_WORD: w[3:0] = s.status_word;
      `REG_PC: w[`PC_W-1:0] = s.pc;
      `REG_INSTR: w[`INSTR_W-1:0] = s.instr;
      `REG_RESULT:
      begin
        w[`RES_BUSY_BIT] = (s.state != ST_IDLE);
        w[`RES_TAKEN_BIT] = s.last_taken;
        w[`RES_UNIMPL_BIT] = s.unimpl;
        w[`RES_CYC_LSB +: 3] = s.cycles;
      end
      `REG_TARGET: w[`PC_W-1:0] = s.target;
      default: w = 32'h00000000;
    endcase
    read_word = w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////
  // Address arithmetic

  // A valid AHB address phase aimed at this slave
  assign addr_phase = hsel && htrans[1] && hready;

  // offset bits taken as two's complement
  assign offset = st.instr[`OFS_W-1:0];

  // sequential advance by one instruction word
  assign seq_pc = st.pc + `INSTR_BYTES;

  // next address plus twice the sign-extended offset
  // offset shifted left once: instructions, not bytes
  assign jump_pc = seq_pc + {{(`PC_W-`OFS_W-1){offset[`OFS_W-1]}}, offset, 1'b0};

  // base core takes 2 cycles when taken
  // enhanced core takes 4 cycles when taken
  assign taken_cycles = st.enhanced ? `CYC_TAKEN_ENH : `CYC_TAKEN_BASE;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_st = st;
    // Pulses last one cycle only
    next_st.pc_load = 1'b0;
    next_st.nop_load = 1'b0;
    next_st.hreadyout = 1'b1;
    next_st.hresp = 1'b0;
    next_st.hrdata = 32'h00000000;

    // Capture the address phase; zero wait states on every access
    next_st.ph_valid = addr_phase;
    next_st.ph_write = hwrite;
    next_st.ph_addr = haddr[7:0];
    // Read data are registered here so they stand through the data phase
    if (addr_phase && !hwrite)
    begin
      next_st.hrdata = read_word(haddr[7:0], st);
    end

    // Data phase of a write: apply hwdata at the captured address
    if (st.ph_valid && st.ph_write)
    begin
      unique case (st.ph_addr)
        `REG_CTRL:
        begin
          next_st.enhanced = hwdata[`CTRL_ENHANCED_BIT];
          next_st.dsp_present = hwdata[`CTRL_DSP_BIT];
        end
        `REG_STATUS_WORD: next_st.status_word = hwdata[3:0];
        `REG_PC:
        begin
          // Moving the counter under a running branch would corrupt it
          if (st.state == ST_IDLE)
          begin
            next_st.pc = hwdata[`PC_W-1:0];
          end
        end
        `REG_INSTR:
        begin
          // A new branch is only accepted once the last one has retired
          if (st.state == ST_IDLE)
          begin
            next_st.instr = hwdata[`INSTR_W-1:0];
            next_st.state = ST_EXEC;
          end
        end
        default: next_st.ph_valid = 1'b0;
      endcase
    end

    // Branch sequencer
    unique case (st.state)
      ST_IDLE:
      begin
        next_st.wait_cnt = 2'h0;
      end
      ST_EXEC:
      begin
        // condition judged on the status word as it stands now
        if (!verdict.known)
        begin
          // Unimplemented encoding: counter left alone, flagged for software
          next_st.unimpl = 1'b1;
          next_st.last_taken = 1'b0;
          next_st.cycles = `CYC_NOT_TAKEN;
          next_st.state = ST_IDLE;
        end
        else if (verdict.taken)
        begin
          next_st.unimpl = 1'b0;
          next_st.last_taken = 1'b1;
          next_st.cycles = taken_cycles;
          next_st.pc = jump_pc;
          next_st.target = jump_pc;
          next_st.pc_load = 1'b1;
          next_st.nop_load = 1'b1;
          // flush cycles left after the first flush cycle
          next_st.wait_cnt = 2'(taken_cycles - 3'h2);
          next_st.state = ST_FLUSH;
        end
        else
        begin
          // untaken: step on by one word in a single cycle
          next_st.unimpl = 1'b0;
          next_st.last_taken = 1'b0;
          next_st.cycles = `CYC_NOT_TAKEN;
          next_st.pc = seq_pc;
          next_st.target = seq_pc;
          next_st.pc_load = 1'b1;
          next_st.state = ST_IDLE;
        end
      end
      ST_FLUSH:
      begin
        // flush cycles after a taken branch: one in the base core, three in the enhanced core
        if (st.wait_cnt == 2'h0)
        begin
          next_st.state = ST_IDLE;
        end
        else
        begin
          next_st.wait_cnt = st.wait_cnt - 2'h1;
        end
      end
      default:
      begin
        next_st.state = ST_IDLE;
      end
    endcase
    // status word is written only by software, never by a branch
    // Busy is registered so the output comes straight from a flop
    next_st.busy = (next_st.state != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.state <= ST_IDLE;
      st.enhanced <= 1'(`CTRL_RESET >> `CTRL_ENHANCED_BIT);
      st.status_word <= `SW_RESET;
      st.pc <= `PC_RESET;
      st.hreadyout <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign pc_value = st.pc;
  assign pc_load = st.pc_load;
  assign nop_load = st.nop_load;
  assign busy = st.busy;

endmodule : conditional_branch_unit

// *** testbench/branch_unit_properties.sv ***
// Port-level assertions for the conditional branch unit
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module branch_unit_properties (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic hready, // AHB ready
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic [31:0] hrdata, // AHB read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Slave response
  input wire logic [`PC_W-1:0] pc_value, // Program counter
  input wire logic pc_load, // Counter update pulse
  input wire logic nop_load, // Squash pulse
  input wire logic busy // Branch in progress
);
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Zero wait states and OKAY only
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_nop_pair; nop_load |-> pc_load; endproperty
  a_nop_pair: assert property (p_nop_pair) else $error("NOP without counter load");
  property p_pulse; pc_load |=> !pc_load; endproperty
  a_pulse: assert property (p_pulse) else $error("pc_load wider than one cycle");
  // An accepted INSTR write starts execution two edges later
  property p_start;
    (hsel && htrans[1] && hready && hwrite && haddr[7:0] == `REG_INSTR && !busy) |=> ##1 busy;
  endproperty
  a_start: assert property (p_start) else $error("branch did not start");
  property p_bound; $rose(busy) |-> ##[1:4] !busy; endproperty
  a_bound: assert property (p_bound) else $error("branch longer than 4 cycles");
  property p_exec; pc_load |-> $past(busy); endproperty
  a_exec: assert property (p_exec) else $error("pc_load outside execution");
  // Read data only in a read data phase
  property p_rdata; !$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("hrdata not zero when idle");
  property p_step; pc_load && !nop_load |-> pc_value == $past(pc_value) + `INSTR_BYTES; endproperty
  a_step: assert property (p_step) else $error("untaken step not plus 2");
endmodule : branch_unit_properties

// *** testbench/fetch_model.sv ***
// Fetch and program counter model on the far side of the branch unit
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module fetch_model (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic [`PC_W-1:0] pc_value, // Counter from the unit
  input wire logic pc_load, // Counter update pulse
  input wire logic nop_load, // Squash pulse
  output logic [`PC_W-1:0] fetch_pc, // Address now fetched
  output logic [7:0] load_cnt, // Reloads seen
  output logic [7:0] squash_cnt // Followers replaced by NOP
);
  // Fetch follows only the pulse, so a stale pc_value is never used
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_pc <= `PC_RESET;
      load_cnt <= 8'h00;
      squash_cnt <= 8'h00;
    end
    else
    begin
      if (pc_load) fetch_pc <= pc_value;
      load_cnt <= load_cnt + {7'h00, pc_load};
      squash_cnt <= squash_cnt + {7'h00, nop_load};
    end
  end
endmodule : fetch_model

// *** testbench/conditional_branch_unit_tb.sv ***
// Self-checking bench for the conditional branch unit
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module conditional_branch_unit_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy_q = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, pc_load, nop_load, busy;
  logic [`PC_W-1:0] pc_value, fetch_pc;
  logic [7:0] load_cnt, squash_cnt;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h40};
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  // Bus ready is the single slave's ready
  conditional_branch_unit i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pc_value(pc_value),
    .pc_load(pc_load), .nop_load(nop_load), .busy(busy));
  fetch_model i_fetch (.sys_clk(sys_clk), .rst_n(rst_n), .pc_value(pc_value),
    .pc_load(pc_load), .nop_load(nop_load), .fetch_pc(fetch_pc), .load_cnt(load_cnt),
    .squash_cnt(squash_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Pre-edge capture avoids racing the registered read data
  always @(posedge sys_clk)
  begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("Counts: %0d checks, %0d mismatches", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic edge_ready;
    @(posedge sys_clk);
    #1;
    while (rdy_q !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask : edge_ready

  // One single word transfer; read data lands in q
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_ready();
    q = rd_q;
  endtask : xfer

  // Status is written just before the instruction, from counter 0x002000
  task automatic run_case(input logic [1:0] ctl, input logic [3:0] sw, input logic [7:0] opc,
    input logic [15:0] ofs, input logic tk, input logic un);
    logic [`PC_W-1:0] exp_pc;
    logic [2:0] cy;
    logic [7:0] l0;
    logic [7:0] s0;
    int n;
    exp_pc = un ? 24'h002000 : 24'h002002 + (tk ? {{7{ofs[15]}}, ofs, 1'b0} : 24'h0);
    cy = tk ? (ctl[0] ? `CYC_TAKEN_ENH : `CYC_TAKEN_BASE) : `CYC_NOT_TAKEN;
    l0 = load_cnt;
    s0 = squash_cnt;
    xfer(1'b1, `REG_CTRL, {30'h0, ctl});
    xfer(1'b1, `REG_PC, 32'h00002000);
    xfer(1'b1, `REG_STATUS_WORD, {28'h0, sw});
    xfer(1'b1, `REG_INSTR, {8'h00, opc, ofs});
    n = 0;
    while (busy !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    xfer(1'b0, `REG_PC, 32'h0);
    check("pc", {8'h0, exp_pc}, q);
    if (!un) check("fetch_pc", {8'h0, exp_pc}, {8'h0, fetch_pc});
    xfer(1'b0, `REG_RESULT, 32'h0);
    check("result", {25'h0, cy, 1'b0, un, tk, 1'b0}, q);
    xfer(1'b0, `REG_STATUS_WORD, 32'h0);
    check("status", {28'h0, sw}, q);
    check("loads", {24'h0, l0 + {7'h0, !un}}, {24'h0, load_cnt});
    check("squash", {24'h0, s0 + {7'h0, tk}}, {24'h0, squash_cnt});
    $display("Test done: opcode %h", opc);
  endtask : run_case

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    xfer(1'b1, 8'h40, 32'hFFFFFFFF);
    foreach (ra[i])
    begin
      xfer(1'b0, ra[i], 32'h0);
      check("reset_or_unmapped", 32'h0, q);
    end
    $display("Test done: reset values");
    run_case(2'h0, 4'h2, `OPC_UNLESS_WRAP, 16'h0005, 1'b1, 1'b0);
    run_case(2'h0, 4'h1, `OPC_UNLESS_WRAP, 16'h0005, 1'b0, 1'b0);
    run_case(2'h0, 4'h0, `OPC_UNLESS_EQUAL, 16'h8000, 1'b1, 1'b0);
    run_case(2'h1, 4'h2, `OPC_UNLESS_EQUAL, 16'h7FFF, 1'b0, 1'b0);
    run_case(2'h3, 4'h4, `OPC_ACC_A_OVF, 16'h7FFF, 1'b1, 1'b0);
    run_case(2'h2, 4'hB, `OPC_ACC_A_OVF, 16'h0010, 1'b0, 1'b0);
    run_case(2'h2, 4'h8, `OPC_ACC_B_OVF, 16'hFFFF, 1'b1, 1'b0);
    run_case(2'h0, 4'h8, `OPC_ACC_B_OVF, 16'h0003, 1'b0, 1'b1);
    run_case(2'h1, 4'h1, `OPC_WRAP, 16'hFFFE, 1'b1, 1'b0);
    run_case(2'h0, 4'hE, `OPC_WRAP, 16'h0004, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : conditional_branch_unit_tb

bind conditional_branch_unit branch_unit_properties i_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pc_value(pc_value), .pc_load(pc_load), .nop_load(nop_load), .busy(busy));
